/* hw/step_atten_pkg.sv */
// Shared constants and types for the step attenuator serial control block.
package step_atten_pkg;

    // Width of the attenuation control word, one bit per binary-weighted step.
    localparam int WORD_W = 6;

    // Positions of the first and the final bit of a serial word.
    localparam int FIRST_SHIFTED_BIT = 5;
    localparam int FINAL_SHIFTED_BIT = 0;

    // APB register map, byte addresses of 32-bit aligned words.
    localparam int APB_ADDR_W = 8;
    localparam int APB_DATA_W = 32;
    localparam logic [APB_ADDR_W-1:0] OFS_CTRL = 8'h00;
    localparam logic [APB_ADDR_W-1:0] OFS_STATUS = 8'h04;
    localparam logic [APB_ADDR_W-1:0] OFS_SOFT_WORD = 8'h08;
    localparam logic [APB_ADDR_W-1:0] OFS_BIT_COUNT = 8'h0c;

    // Control register fields and reset value.
    localparam int CTRL_STROBE_EN_BIT = 0;
    localparam logic CTRL_STROBE_EN_RESET = 1'h1;

    // Status register fields.
    localparam int STATUS_SETTING_LSB = 0;
    localparam int STATUS_SHIFT_LSB = 8;
    localparam int STATUS_STROBE_BIT = 16;
    localparam int STATUS_SHORT_BIT = 17;
    localparam int STATUS_LOADED_BIT = 18;

    // Reference clock and strobe width timing.
    localparam int REF_CLK_PERIOD_NS = 8;
    localparam int STROBE_MIN_PW_NS = 30;
    localparam int STROBE_MIN_PW_CYC = (STROBE_MIN_PW_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;
    localparam int STROBE_CNT_W = $clog2(STROBE_MIN_PW_CYC + 1);

    // Cycles after reset release before the parallel levels are trusted.
    localparam int POWERUP_CYCLES = 3;
    localparam int POWERUP_CNT_W = $clog2(POWERUP_CYCLES + 1);

    // The control word, most significant step first.
    typedef struct packed {
        logic step_16db_ctl;
        logic step_8db_ctl;
        logic step_4db_ctl;
        logic step_2db_ctl;
        logic step_1db_ctl;
        logic step_half_db_ctl;
    } step_word_t;

    // Operating phase of the register-clock side.
    typedef enum logic {
        ST_POWERUP,
        ST_RUN
    } mode_t;

endpackage

/* hw/step_atten_shifter.sv */
// Serial shift register running on the controller's serial clock.
`timescale 1ns/1ns

module step_atten_shifter (
    // Link clock and reset.
    input wire logic serial_clk_i,
    input wire logic arst_n_i,
    // Serial data pin, launched by the controller on its own clock.
    input wire logic serial_data_i,
    // Shift contents and a toggle that flips once per sampled bit.
    output step_atten_pkg::step_word_t shift_word_o,
    output logic shift_toggle_o
);

    typedef struct packed {
        step_atten_pkg::step_word_t shift;
        logic toggle;
    } shifter_state_t;

    shifter_state_t cur;
    shifter_state_t next_state;

    // Each bit moves toward the top and the new bit enters at the bottom, so the
    // first bit of a word ends in the top place. The strobe is not looked at here.
    always_comb begin
        next_state = cur;
        next_state.shift = step_atten_pkg::step_word_t'({cur.shift[step_atten_pkg::WORD_W-2:0], serial_data_i});
        // The toggle tells the other domain that the word moved and is stable.
        next_state.toggle = ~cur.toggle;
    end

    // Sampling on the rising edge; the strobe plays no part in shifting.
    always_ff @(posedge serial_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur <= '0;
        end else begin
            cur <= next_state;
        end
    end

    // Outputs come straight from the flip-flops.
    assign shift_word_o = cur.shift;
    assign shift_toggle_o = cur.toggle;

endmodule

/* hw/step_attenuator_serial_ctl.sv */
// Serial control path and output latch of the step attenuator, with an APB slave.
//
// Our own choices: the register offsets and the APB register port.
`timescale 1ns/1ns

// Behaviour
// - Six weighted control bits, 16 down to 0.5 dB, give 64 settings.
// - A six-stage serial shift register feeds the control bits through a latch.
// - Shifting goes on whatever level the hold strobe has.
// - While the strobe is high the latch passes the shift contents through.
// - When the strobe falls the latch holds its word until raised again; here a SOFT_WORD write can still replace the held word.
// - Words go most significant bit first; the 16 dB bit enters first.
// - The shift register samples serial data on the serial clock rising edge.
// - After power-up the control bits load from the six parallel inputs.
module step_attenuator_serial_ctl #(
    parameter int BIT_COUNT_W = 16
) (
    // Register clock and reset.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    // Serial link from the external controller.
    input wire logic serial_clk_i,
    input wire logic serial_data_i,
    input wire logic word_hold_strobe_i,
    // Parallel levels that choose the setting taken after reset.
    input wire logic [step_atten_pkg::WORD_W-1:0] powerup_steps_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [step_atten_pkg::APB_ADDR_W-1:0] paddr_i,
    input wire logic [step_atten_pkg::APB_DATA_W-1:0] pwdata_i,
    output logic [step_atten_pkg::APB_DATA_W-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Attenuation control bits.
    output logic step_16db_ctl_o,
    output logic step_8db_ctl_o,
    output logic step_4db_ctl_o,
    output logic step_2db_ctl_o,
    output logic step_1db_ctl_o,
    output logic step_half_db_ctl_o
);

    // The transfer counter must fit in one APB data word.
    if (BIT_COUNT_W < 1 || BIT_COUNT_W > step_atten_pkg::APB_DATA_W) begin : g_bad_count_w
        $error("BIT_COUNT_W must lie between 1 and the APB data width.");
    end

    // Depth of every pin synchroniser in this module.
    localparam int PIN_SYNC_DEPTH = 2;

    // A load before both crossing flops fill would take their reset value.
    if (step_atten_pkg::POWERUP_CYCLES <= PIN_SYNC_DEPTH) begin : g_bad_powerup
        $error("POWERUP_CYCLES must exceed the pin crossing depth.");
    end

    // The strobe width check needs at least one cycle.
    if (step_atten_pkg::STROBE_MIN_PW_CYC < 1) begin : g_bad_strobe_min
        $error("STROBE_MIN_PW_CYC must be at least one.");
    end

    // Register map, one aligned word each; other addresses get an error.
    // CTRL bit 0 lets the hold strobe act; it is set after reset.
    // STATUS shows setting, shift copy, strobe, short flag and load done.
    // SOFT_WORD sets the held word while the strobe is not live.
    // BIT_COUNT counts sampled serial bits and wraps; a write clears it.

    // Register clock side state, all in one record.
    typedef struct packed {
        step_atten_pkg::mode_t mode;
        logic [step_atten_pkg::POWERUP_CNT_W-1:0] pu_cnt;
        logic tog_s1;
        logic tog_s2;
        logic tog_s3;
        logic strb_s1;
        logic strb_s2;
        logic strb_s3;
        logic [step_atten_pkg::WORD_W-1:0] pin_s1;
        logic [step_atten_pkg::WORD_W-1:0] pin_s2;
        step_atten_pkg::step_word_t shadow;
        step_atten_pkg::step_word_t setting;
        logic strobe_en;
        logic short_pulse;
        logic [step_atten_pkg::STROBE_CNT_W-1:0] strb_cnt;
        logic [BIT_COUNT_W-1:0] bit_count;
        logic [step_atten_pkg::APB_DATA_W-1:0] prdata;
        logic pslverr;
    } state_t;

    localparam state_t RESET_STATE = '{
        mode: step_atten_pkg::ST_POWERUP,
        strobe_en: step_atten_pkg::CTRL_STROBE_EN_RESET,
        default: '0
    };

    localparam logic [step_atten_pkg::POWERUP_CNT_W-1:0] PU_LAST =
        step_atten_pkg::POWERUP_CNT_W'(step_atten_pkg::POWERUP_CYCLES - 1);
    localparam logic [step_atten_pkg::STROBE_CNT_W-1:0] STRB_MIN =
        step_atten_pkg::STROBE_CNT_W'(step_atten_pkg::STROBE_MIN_PW_CYC);

    state_t cur;
    state_t next_state;

    // Signals from the serial clock domain.
    step_atten_pkg::step_word_t shift_word;
    logic shift_toggle;

    // Decoded bus and link events.
    logic bus_setup;
    logic bus_write;
    logic bit_event;
    logic strobe_live;
    logic strobe_fall;
    logic [step_atten_pkg::APB_DATA_W-1:0] read_value;
    logic read_mapped;
    // Per-register write strobes.
    logic wr_ctrl;
    logic wr_status;
    logic wr_soft;
    logic wr_count;

    // True when the bus address selects the word at the given offset.
    function automatic logic reg_hit(
        input logic [step_atten_pkg::APB_ADDR_W-1:0] addr,
        input logic [step_atten_pkg::APB_ADDR_W-1:0] ofs
    );
        reg_hit = (addr == ofs);
    endfunction

    // The shift register lives on the link's own clock.
    step_atten_shifter u_shifter (
        .serial_clk_i(serial_clk_i),
        .arst_n_i(arst_n_i),
        .serial_data_i(serial_data_i),
        .shift_word_o(shift_word),
        .shift_toggle_o(shift_toggle)
    );

    // A changed toggle marks a new stable shift word. The word stays put for a
    // whole serial clock period, far longer than the three flops of delay, so it
    // can be taken without further handshake once the toggle has crossed.
    assign bit_event = cur.tog_s2 ^ cur.tog_s3;

    // The strobe only acts while software leaves it enabled.
    // The fall comes from the third flop, one cycle behind the live level.
    assign strobe_live = cur.strb_s2 & cur.strobe_en;
    assign strobe_fall = cur.strb_s3 & ~cur.strb_s2;

    // The setup phase prepares the answer; the access phase completes at once.
    // A write refused at setup is dropped, as its error answer says.
    assign bus_setup = psel_i & ~penable_i;
    assign bus_write = psel_i & penable_i & pwrite_i & ~cur.pslverr;

    // One write strobe per register.
    assign wr_ctrl = bus_write & reg_hit(paddr_i, step_atten_pkg::OFS_CTRL);
    assign wr_status = bus_write & reg_hit(paddr_i, step_atten_pkg::OFS_STATUS);
    assign wr_soft = bus_write & reg_hit(paddr_i, step_atten_pkg::OFS_SOFT_WORD);
    assign wr_count = bus_write & reg_hit(paddr_i, step_atten_pkg::OFS_BIT_COUNT);

    // Read multiplexer, evaluated during the setup phase.
    // Unlisted addresses read zero.
    always_comb begin
        read_value = '0;
        read_mapped = 1'b1;
        if (reg_hit(paddr_i, step_atten_pkg::OFS_CTRL)) begin
            read_value[step_atten_pkg::CTRL_STROBE_EN_BIT] = cur.strobe_en;
        end else if (reg_hit(paddr_i, step_atten_pkg::OFS_STATUS)) begin
            read_value[step_atten_pkg::STATUS_SETTING_LSB +: step_atten_pkg::WORD_W] = cur.setting;
            read_value[step_atten_pkg::STATUS_SHIFT_LSB +: step_atten_pkg::WORD_W] = cur.shadow;
            read_value[step_atten_pkg::STATUS_STROBE_BIT] = cur.strb_s2;
            read_value[step_atten_pkg::STATUS_SHORT_BIT] = cur.short_pulse;
            read_value[step_atten_pkg::STATUS_LOADED_BIT] = (cur.mode == step_atten_pkg::ST_RUN);
        end else if (reg_hit(paddr_i, step_atten_pkg::OFS_SOFT_WORD)) begin
            read_value[step_atten_pkg::WORD_W-1:0] = cur.setting;
        end else if (reg_hit(paddr_i, step_atten_pkg::OFS_BIT_COUNT)) begin
            read_value[BIT_COUNT_W-1:0] = cur.bit_count;
        end else begin
            read_mapped = 1'b0;
        end
    end

    // Next state of the register clock side.
    always_comb begin
        next_state = cur;

        // Pins from outside pass two flops before anything reads them.
        // The third strobe and toggle flops only serve edge detection.
        next_state.tog_s1 = shift_toggle;
        next_state.tog_s2 = cur.tog_s1;
        next_state.tog_s3 = cur.tog_s2;
        next_state.strb_s1 = word_hold_strobe_i;
        next_state.strb_s2 = cur.strb_s1;
        next_state.strb_s3 = cur.strb_s2;
        next_state.pin_s1 = powerup_steps_i;
        next_state.pin_s2 = cur.pin_s1;

        // Keep a copy of the shift register on this side. The controller waits
        // after its last serial edge before raising the strobe, and the copy
        // lands within four cycles, so a transparent latch sees the full word.
        // Bits shifted while the latch is open show one by one, a few cycles late.
        if (bit_event) begin
            next_state.shadow = shift_word;
        end

        // Answer of the bus, registered so read data come from flip-flops.
        if (bus_setup) begin
            next_state.prdata = read_mapped ? read_value : '0;
            next_state.pslverr = ~read_mapped;
        end

        // Software controls.
        if (wr_ctrl) begin
            next_state.strobe_en = pwdata_i[step_atten_pkg::CTRL_STROBE_EN_BIT];
        end

        // Latch behaviour after the power-up load.
        // The strobe outranks a direct write, so software cannot fight an open latch.
        case (cur.mode)
            step_atten_pkg::ST_POWERUP: begin
                // Wait until the parallel levels have crossed, then take them.
                // Run is never left again, so the pins are taken only once.
                if (cur.pu_cnt == PU_LAST) begin
                    next_state.setting = step_atten_pkg::step_word_t'(cur.pin_s2);
                    next_state.mode = step_atten_pkg::ST_RUN;
                end else begin
                    next_state.pu_cnt = cur.pu_cnt + 1'b1;
                end
            end
            step_atten_pkg::ST_RUN: begin
                if (strobe_live) begin
                    // Transparent: the shift contents drive the steps.
                    next_state.setting = cur.shadow;
                end else if (wr_soft) begin
                    // A direct write only lands while the latch is closed.
                    next_state.setting = step_atten_pkg::step_word_t'(pwdata_i[step_atten_pkg::WORD_W-1:0]);
                end else begin
                    // Closed: the word caught at the strobe's fall is held.
                    next_state.setting = cur.setting;
                end
            end
            default: begin
                next_state.mode = step_atten_pkg::ST_POWERUP;
                next_state.pu_cnt = '0;
            end
        endcase

        // Measure each strobe pulse. A pulse shorter than the minimum may have
        // been lost in the synchroniser, so it is flagged for software.
        if (cur.strb_s2) begin
            if (cur.strb_cnt != STRB_MIN) begin
                next_state.strb_cnt = cur.strb_cnt + 1'b1;
            end
        end else begin
            next_state.strb_cnt = '0;
        end
        // Writing a one to the short bit clears the flag.
        if (wr_status && pwdata_i[step_atten_pkg::STATUS_SHORT_BIT]) begin
            next_state.short_pulse = 1'b0;
        end
        // Setting wins over a clear in the same cycle.
        if (strobe_fall && cur.strb_cnt < STRB_MIN) begin
            next_state.short_pulse = 1'b1;
        end

        // Count the serial bits received; a write clears, and a bit in the same
        // cycle still counts.
        // The count wraps, so software treats it as an activity figure.
        if (wr_count) begin
            next_state.bit_count = '0;
        end
        if (bit_event) begin
            next_state.bit_count = next_state.bit_count + 1'b1;
        end
    end

    // One register stage for the whole side.
    // Reset clears the latch to zero until the pin load lands.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cur <= RESET_STATE;
        end else begin
            cur <= next_state;
        end
    end

    // Bus outputs; the slave never adds wait states.
    assign pready_o = psel_i & penable_i;
    assign prdata_o = cur.prdata;
    assign pslverr_o = cur.pslverr;

    // Weighted step controls, straight from the latch flops.
    // All six sit in one record, so they change on the same edge.
    assign step_16db_ctl_o = cur.setting.step_16db_ctl;
    assign step_8db_ctl_o = cur.setting.step_8db_ctl;
    assign step_4db_ctl_o = cur.setting.step_4db_ctl;
    assign step_2db_ctl_o = cur.setting.step_2db_ctl;
    assign step_1db_ctl_o = cur.setting.step_1db_ctl;
    assign step_half_db_ctl_o = cur.setting.step_half_db_ctl;

endmodule

/* verification/step_attenuator_serial_ctl_props.sv */
// Assertion checker for the step attenuator serial control block.
`timescale 1ns/1ns
module step_attenuator_serial_ctl_props (
    // Clocks and reset.
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic serial_clk_i,
    // Serial link and power-up pins.
    input wire logic serial_data_i,
    input wire logic word_hold_strobe_i,
    input wire logic [5:0] powerup_steps_i,
    // APB.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // Control bits.
    input wire logic step_16db_ctl_o,
    input wire logic step_8db_ctl_o,
    input wire logic step_4db_ctl_o,
    input wire logic step_2db_ctl_o,
    input wire logic step_1db_ctl_o,
    input wire logic step_half_db_ctl_o
);
    logic [5:0] word;
    logic [5:0] shadow;
    logic sclk_q;
    logic [3:0] rise_cnt;
    logic [3:0] high_cnt;
    logic [3:0] low_cnt;
    logic [3:0] wr_cnt;
    logic [3:0] run_cnt;
    logic en;
    // Saturating count of cycles since a condition was last seen.
    function automatic logic [3:0] bump(input logic [3:0] c, input logic clr);
        return clr ? 4'h0 : ((c == 4'hf) ? c : c + 4'h1);
    endfunction
    assign word = {step_16db_ctl_o, step_8db_ctl_o, step_4db_ctl_o, step_2db_ctl_o, step_1db_ctl_o, step_half_db_ctl_o};
    // Reference shift register on the link clock, most significant bit first.
    always_ff @(posedge serial_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) shadow <= 6'h00;
        else shadow <= {shadow[4:0], serial_data_i};
    end
    // Settling counters; the margins cover the two-flop crossings inside the block.
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sclk_q <= 1'b0;
            rise_cnt <= 4'h0;
            high_cnt <= 4'h0;
            low_cnt <= 4'h0;
            wr_cnt <= 4'h0;
            run_cnt <= 4'h0;
            en <= 1'b1;
        end else begin
            sclk_q <= serial_clk_i;
            rise_cnt <= bump(rise_cnt, serial_clk_i && !sclk_q);
            high_cnt <= bump(high_cnt, !word_hold_strobe_i);
            low_cnt <= bump(low_cnt, word_hold_strobe_i);
            wr_cnt <= bump(wr_cnt, psel_i && penable_i && pwrite_i);
            run_cnt <= bump(run_cnt, 1'b0);
            // Mirror of the strobe enable, so a disabled strobe is not judged.
            en <= (psel_i && penable_i && pwrite_i && paddr_i == 8'h00) ? pwdata_i[0] : en;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    // Power-up load done and the link quiet.
    sequence s_settled;
        run_cnt > 4'h7 && rise_cnt > 4'h7;
    endsequence
    property p_powerup_load;
        $rose(arst_n_i) |-> ##[2:5] word == powerup_steps_i;
    endproperty
    a_powerup_load: assert property (p_powerup_load) else $error("power-up setting not loaded");
    property p_hold_low;
        run_cnt > 4'h7 && low_cnt > 4'h5 && wr_cnt > 4'h2 && !(psel_i && penable_i && pwrite_i) |=> $stable(word);
    endproperty
    a_hold_low: assert property (p_hold_low) else $error("setting moved while strobe low");
    property p_capture;
        s_settled ##0 ($fell(word_hold_strobe_i) && high_cnt > 4'h3 && en) |-> (word == shadow) [*6];
    endproperty
    a_capture: assert property (p_capture) else $error("latch lost word on strobe fall");
    property p_open;
        s_settled ##0 ($rose(word_hold_strobe_i) && en) |-> ##[1:6] word == shadow;
    endproperty
    a_open: assert property (p_open) else $error("latch did not open");
    property p_follow;
        run_cnt > 4'h7 && high_cnt > 4'h7 && en && $rose(serial_clk_i) |-> ##[2:8] word == shadow;
    endproperty
    a_follow: assert property (p_follow) else $error("open latch not following shifts");
    property p_soft_refused;
        s_settled ##0 (en && high_cnt > 4'h7 && psel_i && penable_i && pwrite_i && paddr_i == 8'h08)
            |=> (word == shadow) [*3];
    endproperty
    a_soft_refused: assert property (p_soft_refused) else $error("register write overrode open latch");
    property p_unmapped;
        psel_i && penable_i && paddr_i > 8'h0c |-> pslverr_o && prdata_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_ready;
        pready_o == (psel_i && penable_i);
    endproperty
    a_ready: assert property (p_ready) else $error("pready not tied to access phase");
endmodule
bind step_attenuator_serial_ctl step_attenuator_serial_ctl_props u_step_attenuator_serial_ctl_props (
    .ref_clk_i, .arst_n_i, .serial_clk_i, .serial_data_i, .word_hold_strobe_i, .powerup_steps_i,
    .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
    .step_16db_ctl_o, .step_8db_ctl_o, .step_4db_ctl_o, .step_2db_ctl_o, .step_1db_ctl_o, .step_half_db_ctl_o
);

/* verification/serial_word_sender.sv */
// Behavioural model of the external controller on the serial link.
`timescale 1ns/1ns
module serial_word_sender (
    // Serial link pins.
    output logic serial_clk_o,
    output logic serial_data_o,
    output logic word_hold_strobe_o
);
    // Clock rests low between words; data falls to its pull-down after the hold time.
    initial begin
        serial_clk_o = 1'b0;
        serial_data_o = 1'b0;
        word_hold_strobe_o = 1'b0;
    end
    // The 3 ns offset keeps link edges away from the register clock edges.
    task automatic shift_word(input logic [5:0] w);
        #3;
        for (int i = 5; i >= 0; i--) begin
            #10 serial_data_o = w[i];
            #30 serial_clk_o = 1'b1;
            #40 serial_clk_o = 1'b0;
        end
        #10 serial_data_o = 1'b0;
    endtask
    // Strobe rises well after the last falling edge and stays up 40 ns.
    task automatic pulse_strobe();
        #30 word_hold_strobe_o = 1'b1;
        #40 word_hold_strobe_o = 1'b0;
    endtask
    // Parks the strobe at the given level; high gives transparent operation.
    task automatic set_strobe(input logic lvl);
        #2 word_hold_strobe_o = lvl;
    endtask
endmodule

/* verification/step_attenuator_serial_ctl_tb.sv */
// Self-checking testbench for the step attenuator serial control block.
`timescale 1ns/1ns
module step_attenuator_serial_ctl_tb;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic serial_clk_i;
    logic serial_data_i;
    logic word_hold_strobe_i;
    logic [5:0] powerup_steps_i = 6'h2d;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [7:0] paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic step_16db_ctl_o;
    logic step_8db_ctl_o;
    logic step_4db_ctl_o;
    logic step_2db_ctl_o;
    logic step_1db_ctl_o;
    logic step_half_db_ctl_o;
    logic [5:0] word;
    logic [31:0] rd;
    logic err;
    int error_cnt = 0;
    int n_checks = 0;
    assign word = {step_16db_ctl_o, step_8db_ctl_o, step_4db_ctl_o, step_2db_ctl_o, step_1db_ctl_o, step_half_db_ctl_o};
    // 125 MHz register clock.
    always #4 ref_clk_i = ~ref_clk_i;
    step_attenuator_serial_ctl u_step_attenuator_serial_ctl (
        .ref_clk_i, .arst_n_i, .serial_clk_i, .serial_data_i, .word_hold_strobe_i, .powerup_steps_i,
        .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o,
        .step_16db_ctl_o, .step_8db_ctl_o, .step_4db_ctl_o, .step_2db_ctl_o, .step_1db_ctl_o, .step_half_db_ctl_o
    );
    serial_word_sender u_serial_word_sender (
        .serial_clk_o(serial_clk_i), .serial_data_o(serial_data_i), .word_hold_strobe_o(word_hold_strobe_i)
    );
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Covers the crossing latency of the strobe and shift copy with margin.
    task automatic settle();
        repeat (10) @(posedge ref_clk_i);
    endtask
    // One APB transfer, then one idle cycle so the next setup never collides.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel_i <= 1'b1;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        // Wait as long as the slave asks; only the watchdog ends a hang.
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        rd = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    task automatic do_reset(input logic [5:0] pins);
        powerup_steps_i <= pins;
        arst_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        arst_n_i <= 1'b1;
        settle();
    endtask
    // Setting comes from the pins once; later pin changes are ignored.
    task automatic t_powerup(input logic [5:0] pins);
        check("powerup word", word, pins);
        apb(1'b0, step_atten_pkg::OFS_STATUS, 32'h0);
        check("loaded flag", rd[18], 1'b1);
        powerup_steps_i <= ~pins;
        settle();
        check("pins ignored", word, pins);
    endtask
    task automatic t_regs();
        apb(1'b0, step_atten_pkg::OFS_CTRL, 32'h0);
        check("ctrl reset", rd, 32'h1);
        apb(1'b0, 8'h10, 32'h0);
        check("unmapped err", err, 1'b1);
        check("unmapped data", rd, 32'h0);
        apb(1'b1, step_atten_pkg::OFS_BIT_COUNT, 32'h0);
    endtask
    // Each weight and both extremes: shifted with the strobe low, then latched.
    task automatic t_words();
        logic [5:0] tbl [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h3f};
        logic [5:0] prev;
        foreach (tbl[i]) begin
            prev = word;
            u_serial_word_sender.shift_word(tbl[i]);
            @(posedge ref_clk_i);
            check("held while shifting", word, prev);
            apb(1'b0, step_atten_pkg::OFS_STATUS, 32'h0);
            check("shift copy", rd[13:8], tbl[i]);
            u_serial_word_sender.pulse_strobe();
            @(posedge ref_clk_i);
            settle();
            check("latched word", word, tbl[i]);
        end
        apb(1'b0, step_atten_pkg::OFS_BIT_COUNT, 32'h0);
        check("bit count", rd, 32'h30);
    endtask
    // Register write sets a held latch only; an open latch follows live shifting.
    task automatic t_follow();
        apb(1'b1, step_atten_pkg::OFS_SOFT_WORD, 32'h15);
        settle();
        check("soft word", word, 6'h15);
        u_serial_word_sender.set_strobe(1'b1);
        settle();
        check("open latch", word, 6'h3f);
        u_serial_word_sender.shift_word(6'h2a);
        @(posedge ref_clk_i);
        settle();
        check("follows shifts", word, 6'h2a);
        apb(1'b1, step_atten_pkg::OFS_SOFT_WORD, 32'h0f);
        settle();
        check("soft refused", word, 6'h2a);
        u_serial_word_sender.set_strobe(1'b0);
        settle();
        u_serial_word_sender.shift_word(6'h05);
        @(posedge ref_clk_i);
        settle();
        check("held after fall", word, 6'h2a);
    endtask
    // A disabled strobe leaves the held word alone; enabled again it latches.
    task automatic t_gate();
        apb(1'b1, step_atten_pkg::OFS_CTRL, 32'h0);
        u_serial_word_sender.shift_word(6'h33);
        u_serial_word_sender.pulse_strobe();
        @(posedge ref_clk_i);
        settle();
        check("strobe disabled", word, 6'h2a);
        apb(1'b1, step_atten_pkg::OFS_CTRL, 32'h1);
        u_serial_word_sender.pulse_strobe();
        @(posedge ref_clk_i);
        settle();
        check("strobe enabled", word, 6'h33);
    endtask
    initial begin
        do_reset(6'h2d);
        t_powerup(6'h2d);
        t_regs();
        t_words();
        t_follow();
        t_gate();
        do_reset(6'h07);
        t_powerup(6'h07);
        stop_test();
    end
    // Watchdog far beyond the roughly 8 us the sequence needs.
    initial begin
        #200000;
        error_cnt++;
        stop_test();
    end
endmodule
